// >>> src/sbs_regs.svh
// Constants for the sync burst SRAM control block
`ifndef SBS_REGS_SVH
`define SBS_REGS_SVH

// ============================================================
// Mode pin default levels when the pin floats
`define SBS_FT_DEFAULT    1'b1
`define SBS_DCD_DEFAULT   1'b1
`define SBS_SLEEP_DEFAULT 1'b0

// ============================================================
// Burst counter geometry
`define SBS_BURST_LEN     3'h4
`define SBS_BURST_BITS    2

`endif

// >>> src/sbs_pkg.sv
// Types for the sync burst SRAM control block
package sbs_pkg;

    // Cycle kind decoded from the strobes and selects
    typedef enum logic [1:0] {
        SBS_IDLE,
        SBS_READ,
        SBS_WRITE
    } sbs_op_t;

endpackage : sbs_pkg

// >>> src/sbs_burst_ctr.sv
// Two-bit burst address counter with linear or interleaved order
`timescale 1ns/100ps
module sbs_burst_ctr (
    input  wire logic       clk_sys,
    input  wire logic       nrst,
    input  wire logic       clk_en,
    input  wire logic       load,
    input  wire logic [1:0] preset,
    input  wire logic       advance,
    input  wire logic       linear_order_sel_n,
    output logic      [1:0] burst_addr
);

    logic [1:0] start_r;
    logic [1:0] step_r;
    logic [1:0] step_now;

    // ========================================================
    // Start value and step count
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            start_r <= 2'h0;
            step_r  <= 2'h0;
        end else if (clk_en) begin
            if (load) begin
                start_r <= preset;
                step_r  <= 2'h0;
            end else if (advance) begin
                step_r  <= step_r + 2'h1;
            end
        end
    end

    // ========================================================
    // Address order: add for linear, xor for interleaved
    // An advancing cycle already uses the next burst address
    always_comb begin
        step_now = advance ? step_r + 2'h1 : step_r;
        if (!linear_order_sel_n)
            burst_addr = start_r + step_now;
        else
            burst_addr = start_r ^ step_now;
    end

    chk_linear_wrap: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        (clk_en && !load && advance)[*4] |=> (step_r == $past(step_r, 4)))
        else $error("burst count did not wrap after four");

    chk_hold_noadv: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        (clk_en && !load && !advance) |=> $stable(step_r))
        else $error("counter moved without advance");

endmodule : sbs_burst_ctr

// >>> src/sbs_skid_buf.sv
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/100ps
module sbs_skid_buf #(
    parameter int WIDTH = 72
) (
    input  wire logic             clk_sys,
    input  wire logic             nrst,
    input  wire logic             clk_en,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);

    logic [WIDTH-1:0] mem_r [2];
    logic             wr_ptr_r;
    logic             rd_ptr_r;
    logic [1:0]       cnt_r;
    logic             push;
    logic             pop;

    initial begin
        if (WIDTH < 1)
            $error("WIDTH must be positive");
    end

    assign in_ready  = (cnt_r != 2'h2);
    assign out_valid = (cnt_r != 2'h0);
    assign out_data  = mem_r[rd_ptr_r];
    assign push      = clk_en && in_valid && in_ready;
    assign pop       = clk_en && out_valid && out_ready;

    // ========================================================
    // Storage
    always_ff @(posedge clk_sys) begin
        if (push)
            mem_r[wr_ptr_r] <= in_data;
    end

    // ========================================================
    // Pointers and count
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            wr_ptr_r <= 1'b0;
            rd_ptr_r <= 1'b0;
            cnt_r    <= 2'h0;
        end else begin
            if (push)
                wr_ptr_r <= ~wr_ptr_r;
            if (pop)
                rd_ptr_r <= ~rd_ptr_r;
            if (push && !pop)
                cnt_r <= cnt_r + 2'h1;
            else if (pop && !push)
                cnt_r <= cnt_r - 2'h1;
        end
    end

endmodule : sbs_skid_buf

// >>> src/sbs_ctrl.sv
// Control logic of a synchronous burst SRAM
`timescale 1ns/100ps
`include "sbs_regs.svh"
module sbs_ctrl #(
    parameter int LANES      = 8,
    parameter int ADDR_WIDTH = 18
) (
    input  wire logic                  clk_sys,
    input  wire logic                  nrst,
    input  wire logic                  clk_en,
    input  wire logic [ADDR_WIDTH-1:0] addr_in,
    input  wire logic                  chip_select_a_n,
    input  wire logic                  chip_select_b,
    input  wire logic                  chip_select_c_n,
    input  wire logic                  cpu_addr_strobe_n,
    input  wire logic                  ctrl_addr_strobe_n,
    input  wire logic                  burst_advance_n,
    input  wire logic                  all_bytes_write_n,
    input  wire logic                  byte_write_gate_n,
    input  wire logic [LANES-1:0]      lane_write_n,
    input  wire logic                  out_enable_n,
    input  wire logic                  sleep_request,
    input  wire logic                  flow_through_sel_n,
    input  wire logic                  linear_order_sel_n,
    input  wire logic                  deselect_mode_sel,
    input  wire logic [LANES*8-1:0]    wr_data_in,
    input  wire logic [LANES*8-1:0]    array_rd_data,
    input  wire logic                  rd_ready,
    output logic      [ADDR_WIDTH-1:0] array_addr,
    output logic      [LANES-1:0]      array_lane_we,
    output logic      [LANES*8-1:0]    array_wr_data,
    output logic                       array_rd_en,
    output logic      [LANES*8-1:0]    rd_data_out,
    output logic                       rd_valid,
    output logic      [LANES-1:0]      lane_oe_n,
    output logic                       standby
);

    // ========================================================
    // Elaboration checks
    initial begin
        if (LANES < 1 || LANES > 8)
            $error("LANES must be 1 to 8");
        if (ADDR_WIDTH < `SBS_BURST_BITS + 1)
            $error("ADDR_WIDTH too small");
    end

    logic                  selected;
    logic                  strobe_any;
    logic                  start_cyc;
    logic                  cont_cyc;
    logic                  active_cyc;
    logic [LANES-1:0]      lane_we;
    logic                  is_write;
    logic                  ld_cpu;
    logic                  ld_ctrl;
    logic                  desel_cyc;
    logic [1:0]            burst_lo;
    logic [ADDR_WIDTH-1:0] base_r;
    logic                  burst_on_r;
    logic                  read_s1_r;
    logic                  drive_r;
    logic                  drive_nxt;
    logic                  rd_q_valid;
    logic [LANES*8-1:0]    rd_pipe_r;
    logic                  rd_pipe_v_r;
    logic [LANES*8-1:0]    buf_in_data;
    logic                  buf_in_valid;
    logic                  buf_in_ready;
    logic                  buf_out_valid;
    logic [LANES*8-1:0]    buf_out_data;
    logic                  run;
    sbs_pkg::sbs_op_t      op;

    // ========================================================
    // Cycle decode of selects and strobes
    assign selected   = !chip_select_a_n && chip_select_b
                        && !chip_select_c_n;
    assign ld_cpu     = !cpu_addr_strobe_n && !chip_select_a_n;
    assign ld_ctrl    = cpu_addr_strobe_n && !ctrl_addr_strobe_n;
    assign strobe_any = ld_cpu || ld_ctrl;
    assign start_cyc  = strobe_any && selected;
    assign desel_cyc  = strobe_any && !selected;
    assign cont_cyc   = !strobe_any && burst_on_r;
    assign active_cyc = start_cyc || cont_cyc;
    // Sleep freezes the control path but keeps the array
    assign run        = clk_en && !sleep_request;

    // ========================================================
    // Byte lane write decode, one lane per generate step
    genvar gi;
    generate
        for (gi = 0; gi < LANES; gi = gi + 1) begin : g_lane
            assign lane_we[gi] = !all_bytes_write_n
                || (!byte_write_gate_n && !lane_write_n[gi]);
        end
    endgenerate

    // A processor strobe start is always a read
    assign is_write = (|lane_we) && !(ld_cpu && start_cyc);

    always_comb begin
        if (!active_cyc)
            op = sbs_pkg::SBS_IDLE;
        else if (is_write)
            op = sbs_pkg::SBS_WRITE;
        else
            op = sbs_pkg::SBS_READ;
    end

    // ========================================================
    // Burst address counter
    sbs_burst_ctr u_ctr (
        .clk_sys            (clk_sys),
        .nrst               (nrst),
        .clk_en             (run),
        .load               (start_cyc),
        .preset             (addr_in[1:0]),
        .advance            (cont_cyc && !burst_advance_n),
        .linear_order_sel_n (linear_order_sel_n),
        .burst_addr         (burst_lo)
    );

    // ========================================================
    // Upper address and burst-in-progress flag
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            base_r     <= '0;
            burst_on_r <= 1'b0;
        end else if (run) begin
            if (start_cyc) begin
                base_r     <= addr_in;
                burst_on_r <= 1'b1;
            end else if (desel_cyc) begin
                burst_on_r <= 1'b0;
            end
        end
    end

    // ========================================================
    // Array request registers
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            array_addr    <= '0;
            array_lane_we <= '0;
            array_wr_data <= '0;
            array_rd_en   <= 1'b0;
        end else if (run) begin
            if (start_cyc)
                array_addr <= addr_in;
            else
                array_addr <= {base_r[ADDR_WIDTH-1:2], burst_lo};
            array_lane_we <= (op == sbs_pkg::SBS_WRITE) ? lane_we : '0;
            array_wr_data <= wr_data_in;
            // Dummy reads with outputs off still fetch and advance
            array_rd_en   <= (op == sbs_pkg::SBS_READ);
        end else if (clk_en) begin
            array_lane_we <= '0;
            array_rd_en   <= 1'b0;
        end
    end

    // ========================================================
    // Read stage tracking, used only for pipeline driver timing
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            read_s1_r <= 1'b0;
        end else if (clk_en) begin
            read_s1_r <= run && (op == sbs_pkg::SBS_READ);
        end
    end

    // ========================================================
    // Output register, used only in pipeline mode
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rd_pipe_r   <= '0;
            rd_pipe_v_r <= 1'b0;
        end else if (clk_en) begin
            rd_pipe_r   <= array_rd_data;
            rd_pipe_v_r <= array_rd_en;
        end
    end

    // Flow-through bypasses the output register
    always_comb begin
        if (!flow_through_sel_n) begin
            buf_in_data = array_rd_data;
            rd_q_valid  = array_rd_en;
        end else begin
            buf_in_data = rd_pipe_r;
            rd_q_valid  = rd_pipe_v_r;
        end
    end
    assign buf_in_valid = rd_q_valid;

    // ========================================================
    // Two-entry buffer toward the reader
    sbs_skid_buf #(
        .WIDTH (LANES*8)
    ) u_buf (
        .clk_sys   (clk_sys),
        .nrst      (nrst),
        .clk_en    (clk_en),
        .in_valid  (buf_in_valid),
        .in_ready  (buf_in_ready),
        .in_data   (buf_in_data),
        .out_valid (buf_out_valid),
        .out_ready (rd_ready || !rd_valid),
        .out_data  (buf_out_data)
    );

    // Reader side registers; buffer stalls when reader holds off
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rd_data_out <= '0;
            rd_valid    <= 1'b0;
        end else if (clk_en) begin
            if (rd_ready || !rd_valid) begin
                rd_valid    <= buf_out_valid;
                rd_data_out <= buf_out_data;
            end
        end
    end

    // ========================================================
    // Driver turn-off: single deselect one stage ahead of dual
    always_comb begin
        if (!flow_through_sel_n)
            drive_nxt = run && (op == sbs_pkg::SBS_READ);
        else
            drive_nxt = read_s1_r;
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            drive_r <= 1'b0;
        end else if (clk_en) begin
            drive_r <= drive_nxt;
        end
    end

    // ========================================================
    // Lane output enables, active low; write cycles stay off
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            lane_oe_n <= '1;
        end else if (clk_en) begin
            if (out_enable_n || (run && op == sbs_pkg::SBS_WRITE))
                lane_oe_n <= '1;
            else if (deselect_mode_sel ? drive_nxt
                                       : (drive_nxt || drive_r))
                lane_oe_n <= '0;
            else
                lane_oe_n <= '1;
        end
    end

    // ========================================================
    // Standby indication
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst)
            standby <= `SBS_SLEEP_DEFAULT;
        else if (clk_en)
            standby <= sleep_request;
    end

    // ========================================================
    // Checks
    chk_oe_write_off: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        (clk_en && run && op == sbs_pkg::SBS_WRITE) |=> (&lane_oe_n))
        else $error("lanes drive during write");

    chk_oe_gate: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        (clk_en && out_enable_n) |=> (&lane_oe_n))
        else $error("lanes drive with output enable high");

    chk_gw_all: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        (run && active_cyc && !all_bytes_write_n && !(ld_cpu && start_cyc))
        |=> (&array_lane_we))
        else $error("all-bytes write missed a lane");

    chk_lane_pick: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        (run && op == sbs_pkg::SBS_WRITE && all_bytes_write_n
         && !byte_write_gate_n)
        |=> (array_lane_we == ~$past(lane_write_n)))
        else $error("gated write picked wrong lanes");

    chk_read_none: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        (run && all_bytes_write_n && byte_write_gate_n)
        |=> (array_lane_we == '0))
        else $error("lane written in read cycle");

    chk_desel_load: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        (run && desel_cyc) |=> !burst_on_r)
        else $error("deselect did not end burst");

    chk_start_addr: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        (run && start_cyc) |=> (array_addr == $past(addr_in)))
        else $error("start address not loaded");

    chk_dummy_read: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        (run && op == sbs_pkg::SBS_READ && out_enable_n) |=> array_rd_en)
        else $error("dummy read skipped");

    chk_sleep_flag: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        (clk_en && sleep_request) |=> standby ##0 (array_lane_we == '0))
        else $error("sleep not honoured");

    cov_read:  cover property (@(posedge clk_sys) disable iff (!nrst)
        run && op == sbs_pkg::SBS_READ);
    cov_write: cover property (@(posedge clk_sys) disable iff (!nrst)
        run && op == sbs_pkg::SBS_WRITE);
    cov_burst: cover property (@(posedge clk_sys) disable iff (!nrst)
        run && cont_cyc && !burst_advance_n);
    cov_stall: cover property (@(posedge clk_sys) disable iff (!nrst)
        !buf_in_ready);

endmodule : sbs_ctrl

// >>> tb/sbs_array_model.sv
// Storage array stand-in on the far side of the control block
`timescale 1ns/100ps
module sbs_array_model (
    input  wire logic        clk_sys,
    input  wire logic [17:0] array_addr,
    input  wire logic [7:0]  array_lane_we,
    input  wire logic [63:0] array_wr_data,
    output logic      [63:0] array_rd_data
);
    logic [63:0] mem_r [16];

    // ========================================
    // Lane writes land on the rising edge
    always_ff @(posedge clk_sys) begin
        for (int i = 0; i < 8; i++) begin
            if (array_lane_we[i]) begin
                mem_r[array_addr[3:0]][8*i +: 8] <= array_wr_data[8*i +: 8];
            end
        end
    end

    // Read path is combinational from the address
    assign array_rd_data = mem_r[array_addr[3:0]];
endmodule : sbs_array_model

// >>> tb/sync_burst_sram_control_test.sv
// Self-checking bench for the sync burst SRAM control block
`timescale 1ns/100ps
module sync_burst_sram_control_test;
    localparam logic [2:0] SEL = 3'h2; // Selected
    localparam logic [2:0] DES = 3'h6; // First select off
    localparam logic [4:0] IDL = 5'h17; // Control strobe only
    localparam logic [4:0] RDP = 5'h0f; // Processor strobe read
    localparam logic [4:0] WRG = 5'h15; // Control strobe, all bytes
    logic        clk_sys = 1'b0;
    logic        nrst = 1'b0;
    logic        clk_en = 1'b1;
    logic [17:0] addr_in = 18'h0;
    logic        chip_select_a_n = 1'b1;
    logic        chip_select_b = 1'b1;
    logic        chip_select_c_n = 1'b0;
    logic        cpu_addr_strobe_n = 1'b1;
    logic        ctrl_addr_strobe_n = 1'b0;
    logic        burst_advance_n = 1'b1;
    logic        all_bytes_write_n = 1'b1;
    logic        byte_write_gate_n = 1'b1;
    logic [7:0]  lane_write_n = 8'hff;
    logic        out_enable_n = 1'b0;
    logic        sleep_request = 1'b0;
    logic        flow_through_sel_n = 1'b1;
    logic        linear_order_sel_n = 1'b0;
    logic        deselect_mode_sel = 1'b1;
    logic [63:0] wr_data_in = 64'h0;
    logic [63:0] array_rd_data;
    logic        rd_ready = 1'b1;
    logic [17:0] array_addr;
    logic [7:0]  array_lane_we;
    logic [63:0] array_wr_data;
    logic        array_rd_en;
    logic [63:0] rd_data_out;
    logic        rd_valid;
    logic [7:0]  lane_oe_n;
    logic        standby;
    int          errors = 0;
    int          compares = 0;

    sbs_ctrl i_dut (
        .clk_sys            (clk_sys),
        .nrst               (nrst),
        .clk_en             (clk_en),
        .addr_in            (addr_in),
        .chip_select_a_n    (chip_select_a_n),
        .chip_select_b      (chip_select_b),
        .chip_select_c_n    (chip_select_c_n),
        .cpu_addr_strobe_n  (cpu_addr_strobe_n),
        .ctrl_addr_strobe_n (ctrl_addr_strobe_n),
        .burst_advance_n    (burst_advance_n),
        .all_bytes_write_n  (all_bytes_write_n),
        .byte_write_gate_n  (byte_write_gate_n),
        .lane_write_n       (lane_write_n),
        .out_enable_n       (out_enable_n),
        .sleep_request      (sleep_request),
        .flow_through_sel_n (flow_through_sel_n),
        .linear_order_sel_n (linear_order_sel_n),
        .deselect_mode_sel  (deselect_mode_sel),
        .wr_data_in         (wr_data_in),
        .array_rd_data      (array_rd_data),
        .rd_ready           (rd_ready),
        .array_addr         (array_addr),
        .array_lane_we      (array_lane_we),
        .array_wr_data      (array_wr_data),
        .array_rd_en        (array_rd_en),
        .rd_data_out        (rd_data_out),
        .rd_valid           (rd_valid),
        .lane_oe_n          (lane_oe_n),
        .standby            (standby)
    );

    sbs_array_model i_array (
        .clk_sys       (clk_sys),
        .array_addr    (array_addr),
        .array_lane_we (array_lane_we),
        .array_wr_data (array_wr_data),
        .array_rd_data (array_rd_data)
    );

    // ========================================
    // Clock
    always #12.5 clk_sys = ~clk_sys;

    function automatic logic [63:0] pat(input logic [17:0] a);
        return {4{a[15:0]}};
    endfunction : pat

    task automatic finish_test();
        if (errors == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : finish_test

    task automatic chk(input logic [63:0] exp, input logic [63:0] got);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask : chk

    // Drive one bus cycle just after a falling edge
    task automatic cyc(input logic [2:0] sel, input logic [4:0] ctl,
                       input logic [7:0] ln, input logic [17:0] a);
        @(negedge clk_sys);
        {chip_select_a_n, chip_select_b, chip_select_c_n} = sel;
        {cpu_addr_strobe_n, ctrl_addr_strobe_n, burst_advance_n,
         all_bytes_write_n, byte_write_gate_n} = ctl;
        lane_write_n = ln;
        addr_in = a;
        wr_data_in = pat(a);
    endtask : cyc

    // Wait for a read word under a bound and compare it
    task automatic take(input logic [63:0] exp);
        int n;
        n = 0;
        while (rd_valid !== 1'b1 && n < 20) begin
            @(negedge clk_sys);
            n++;
        end
        if (rd_valid !== 1'b1) begin
            errors++;
            finish_test();
        end
        chk(exp, rd_data_out);
        @(negedge clk_sys);
    endtask : take

    // One write-control combination and the lanes it must enable
    task automatic wcase(input logic gw, input logic bw,
                         input logic [7:0] ln, input logic [7:0] we);
        cyc(SEL, {3'h5, gw, bw}, ln, 18'h00104);
        cyc(DES, IDL, 8'hff, 18'h0);
        chk(we, array_lane_we);
        chk(we == 8'h00, array_rd_en);
        chk(18'h00104, array_addr);
    endtask : wcase

    // Burst of start, three advances, wrap, then one suspend
    task automatic burst(input logic lin_n, input logic [1:0] s,
                         input logic [7:0] seq);
        logic [11:0] ord;
        logic [4:0]  ctl;
        ord = {2'h0, 2'h0, 2'h3, 2'h2, 2'h1, 2'h0};
        linear_order_sel_n = lin_n;
        for (int i = 0; i < 7; i++) begin
            ctl = (i == 0) ? 5'h14 : (i == 5) ? 5'h1c : 5'h18;
            cyc((i == 6) ? DES : SEL, (i == 6) ? IDL : ctl, 8'hff,
                {16'h0003, s});
            if (i > 0) begin
                chk(seq[2*ord[2*(i-1) +: 2] +: 2], array_addr[1:0]);
            end
        end
    endtask : burst

    // ========================================
    // Main sequence
    initial begin
        repeat (12) @(negedge clk_sys);
        nrst = 1'b1;
        chk(8'hff, lane_oe_n);
        chk(1'b0, standby);
        chk(1'b0, rd_valid);
        wcase(1'b0, 1'b1, 8'hff, 8'hff);
        wcase(1'b1, 1'b0, 8'h5a, 8'ha5);
        wcase(1'b1, 1'b0, 8'hfe, 8'h01);
        wcase(1'b1, 1'b0, 8'h7f, 8'h80);
        wcase(1'b1, 1'b0, 8'hff, 8'h00);
        wcase(1'b1, 1'b1, 8'h00, 8'h00);
        burst(1'b0, 2'h2, {2'h1, 2'h0, 2'h3, 2'h2});
        burst(1'b0, 2'h0, {2'h3, 2'h2, 2'h1, 2'h0});
        burst(1'b1, 2'h1, {2'h2, 2'h3, 2'h0, 2'h1});
        burst(1'b1, 2'h3, {2'h0, 2'h1, 2'h2, 2'h3});
        // Unselected strobes start nothing
        for (int i = 0; i < 3; i++) begin
            cyc((i == 0) ? 3'h6 : (i == 1) ? 3'h0 : 3'h3, 5'h17,
                8'hff, 18'h0);
            cyc(DES, IDL, 8'hff, 18'h0);
            chk(1'b0, array_rd_en);
        end
        // Write all bytes of two words, checking drivers stay off
        cyc(SEL, WRG, 8'hff, 18'h00009);
        cyc(SEL, WRG, 8'hff, 18'h0000a);
        chk(8'hff, lane_oe_n);
        cyc(DES, IDL, 8'hff, 18'h0);
        // Flow-through read with single then dual deselect
        flow_through_sel_n = 1'b0;
        for (int m = 1; m >= 0; m--) begin
            deselect_mode_sel = m[0];
            cyc(SEL, RDP, 8'hff, 18'h00009);
            cyc(DES, IDL, 8'hff, 18'h0);
            chk(18'h00009, array_addr);
            chk(8'h00, lane_oe_n);
            cyc(DES, IDL, 8'hff, 18'h0);
            chk(m ? 8'hff : 8'h00, lane_oe_n);
            take(pat(18'h00009));
        end
        deselect_mode_sel = 1'b1;
        // Dummy read with outputs disabled still advances
        out_enable_n = 1'b1;
        linear_order_sel_n = 1'b0;
        cyc(SEL, RDP, 8'hff, 18'h00009);
        cyc(SEL, 5'h1b, 8'hff, 18'h00009);
        chk(8'hff, lane_oe_n);
        cyc(DES, IDL, 8'hff, 18'h0);
        chk(18'h0000a, array_addr);
        chk(8'hff, lane_oe_n);
        take(pat(18'h00009));
        take(pat(18'h0000a));
        out_enable_n = 1'b0;
        // Pipelined back-to-back reads with the reader stalled
        flow_through_sel_n = 1'b1;
        rd_ready = 1'b0;
        cyc(SEL, RDP, 8'hff, 18'h00009);
        cyc(SEL, RDP, 8'hff, 18'h0000a);
        chk(8'hff, lane_oe_n);
        cyc(DES, IDL, 8'hff, 18'h0);
        chk(8'h00, lane_oe_n);
        repeat (4) @(negedge clk_sys);
        rd_ready = 1'b1;
        take(pat(18'h00009));
        take(pat(18'h0000a));
        // Frozen clock enable ignores a write request
        clk_en = 1'b0;
        cyc(SEL, WRG, 8'hff, 18'h00009);
        cyc(DES, IDL, 8'hff, 18'h0);
        chk(8'h00, array_lane_we);
        clk_en = 1'b1;
        // Sleep ignores a request and keeps contents
        sleep_request = 1'b1;
        cyc(SEL, WRG, 8'hff, 18'h00009);
        cyc(DES, IDL, 8'hff, 18'h0);
        chk(1'b1, standby);
        chk(8'h00, array_lane_we);
        sleep_request = 1'b0;
        cyc(SEL, RDP, 8'hff, 18'h00009);
        cyc(DES, IDL, 8'hff, 18'h0);
        chk(1'b0, standby);
        take(pat(18'h00009));
        finish_test();
    end
endmodule : sync_burst_sram_control_test
